// ---- src/aasic_pkg.sv ----
// Purpose: Shared constants and types of the interrupt controller
// Assumes: 32-bit Avalon-MM register port, one word per register
// Notes: Byte offsets are word aligned
`default_nettype none
package aasic_pkg;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [5:0] OFS_AIE = 6'h00;
	localparam logic [5:0] OFS_APOL = 6'h04;
	localparam logic [5:0] OFS_EICTL = 6'h08;
	localparam logic [5:0] OFS_IEN = 6'h0c;
	localparam logic [5:0] OFS_IPRI = 6'h10;
	localparam logic [5:0] OFS_EIEN = 6'h14;
	localparam logic [5:0] OFS_EIPRI = 6'h18;
	localparam logic [5:0] OFS_TCTL = 6'h1c;
	localparam logic [5:0] OFS_SFLG = 6'h20;
	localparam logic [5:0] OFS_ISTAT = 6'h24;
	localparam logic [5:0] OFS_IMASK = 6'h28;
	localparam logic [5:0] OFS_VSTAT = 6'h2c;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_READ_SELECT = 0;
	localparam int BIT_WDT = 3;
	localparam int BIT_AI = 4;
	localparam int BIT_EAI = 5;
	localparam int BIT_EA = 7;
	localparam int BIT_IT0 = 0;
	localparam int BIT_IE0 = 1;
	localparam int BIT_IT1 = 2;
	localparam int BIT_IE1 = 3;
	localparam int BIT_TF0 = 5;
	localparam int BIT_TF1 = 7;
	localparam int BIT_EV_TAKEN = 0;
	localparam int BIT_EV_AUX = 1;
	// ----------------------------------------
	// Reset values and vectors
	// ----------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_APOL = 8'h00;
	localparam logic [4:0] NUM_AUX = 5'h06;
	localparam logic [2:0] VEC_LOW = 3'h3;
	localparam int NSTD = 12;
	localparam int NEVT = 2;
	// Standard source order: ext0 t0 ext1 t1 ser0 t2 ser1 ext2..5 wdt
	localparam logic [59:0] STD_NUMS = {5'h0c, 5'h0b, 5'h0a, 5'h09, 5'h08, 5'h07,
		5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
	typedef struct packed {
		logic valid;
		logic [4:0] num;
	} aasic_sel_t;
	typedef struct packed {
		logic read;
		logic write;
		logic [5:0] address;
		logic [31:0] writedata;
	} aasic_bus_t;
endpackage : aasic_pkg
`default_nettype wire

// ---- src/aasic_ctrl.sv ----
// Purpose: Auxiliary and standard interrupt controller with vector output
// Assumes: Event inputs from same-clock logic; external pins asynchronous
// Notes: Notes on behaviour follow
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`default_nettype none
module aasic_ctrl (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [5:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic [7:0] i_aux_evt,
	input wire logic [5:0] i_ext_n,
	input wire logic [1:0] i_tmr_ovf,
	input wire logic i_ser0_evt,
	input wire logic i_tmr2_evt,
	input wire logic i_ser1_evt,
	input wire logic i_wdt_evt,
	input wire logic i_vec_ack,
	output logic o_vec_req,
	output logic [7:0] o_vec_addr,
	output logic o_irq
);
	import aasic_pkg::*;
	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [7:0] vec_of(input logic [4:0] num);
		vec_of = {num, VEC_LOW};
	endfunction : vec_of
	function automatic aasic_sel_t pick(input logic [NSTD-1:0] req);
		aasic_sel_t s;
		s = '0;
		for (int i = NSTD - 1; i >= 0; i--) begin
			if (req[i]) begin
				s.valid = 1'b1;
				s.num = STD_NUMS[i*5 +: 5];
			end
		end
		pick = s;
	endfunction : pick
	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	aasic_bus_t bus;
	logic wait_ff;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	assign bus = '{read: i_avs_read, write: i_avs_write, address: i_avs_address,
		writedata: i_avs_writedata};
	wire wr_go = bus.write && !wait_ff;
	wire rd_cap = bus.read && wait_ff;
	wire [7:0] wbyte = bus.writedata[7:0];
	wire wr_aie = wr_go && (bus.address == OFS_AIE);
	wire wr_apol = wr_go && (bus.address == OFS_APOL);
	wire wr_eictl = wr_go && (bus.address == OFS_EICTL);
	wire wr_ien = wr_go && (bus.address == OFS_IEN);
	wire wr_ipri = wr_go && (bus.address == OFS_IPRI);
	wire wr_eien = wr_go && (bus.address == OFS_EIEN);
	wire wr_eipri = wr_go && (bus.address == OFS_EIPRI);
	wire wr_tctl = wr_go && (bus.address == OFS_TCTL);
	wire wr_sflg = wr_go && (bus.address == OFS_SFLG);
	wire wr_istat = wr_go && (bus.address == OFS_ISTAT);
	wire wr_imask = wr_go && (bus.address == OFS_IMASK);
	// One wait cycle per access keeps read data registered
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			wait_ff <= 1'b1;
			rdata_ff <= '0;
		end else begin
			wait_ff <= !((bus.read || bus.write) && wait_ff);
			if (rd_cap) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end
	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	logic [7:0] aie_ff;
	logic [7:0] apol_ff;
	logic eai_ff;
	logic [7:0] ien_ff;
	logic [7:0] ipri_ff;
	logic [4:0] eien_ff;
	logic [4:0] eipri_ff;
	logic [1:0] it_ff;
	logic [NEVT-1:0] imask_ff;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			aie_ff <= RST_BYTE;
			apol_ff <= RST_APOL;
			eai_ff <= 1'b0;
			ien_ff <= RST_BYTE;
			ipri_ff <= RST_BYTE;
			eien_ff <= '0;
			eipri_ff <= '0;
			it_ff <= '0;
			imask_ff <= '0;
		end else begin
			if (wr_aie) aie_ff <= wbyte;
			if (wr_apol) apol_ff <= wbyte;
			if (wr_eictl) eai_ff <= wbyte[BIT_EAI];
			if (wr_ien) ien_ff <= wbyte;
			if (wr_ipri) ipri_ff <= wbyte;
			if (wr_eien) eien_ff <= wbyte[4:0];
			if (wr_eipri) eipri_ff <= wbyte[4:0];
			if (wr_tctl) it_ff <= {wbyte[BIT_IT1], wbyte[BIT_IT0]};
			if (wr_imask) imask_ff <= wbyte[NEVT-1:0];
		end
	end
	// ----------------------------------------
	// Pin synchroniser and edge detect
	// ----------------------------------------
	logic [5:0] pin_m_ff;
	logic [5:0] pin_s_ff;
	logic [5:0] pin_d_ff;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_m_ff <= '1;
			pin_s_ff <= '1;
			pin_d_ff <= '1;
		end else begin
			pin_m_ff <= i_ext_n;
			pin_s_ff <= pin_m_ff;
			pin_d_ff <= pin_s_ff;
		end
	end
	wire [5:0] pin_fall = pin_d_ff & ~pin_s_ff;
	wire [5:0] pin_low = ~pin_s_ff;
	// ----------------------------------------
	// Source flags
	// ----------------------------------------
	// Flag order follows STD_NUMS; aux sits above them
	logic [NSTD-1:0] flag_ff;
	logic [NSTD-1:0] nxt_flag;
	logic [NSTD-1:0] flag_set;
	logic [NSTD-1:0] flag_clr;
	logic [NSTD-1:0] hw_clr;
	logic [NSTD-1:0] sw_clr;
	logic [NSTD-1:0] std_en;
	logic [NSTD-1:0] std_pri;
	aasic_sel_t taken;
	logic req_ff;
	logic [4:0] num_ff;
	wire ack_go = i_vec_ack && req_ff;
	wire [4:0] ack_num = num_ff;
	assign flag_set = {i_wdt_evt, pin_fall[5:2], i_ser1_evt, i_tmr2_evt, i_ser0_evt,
		i_tmr_ovf[1], pin_fall[1], i_tmr_ovf[0], pin_fall[0]};
	// Only edge externals and timers 0/1 clear on vectoring
	always_comb begin
		hw_clr = '0;
		for (int i = 0; i < NSTD; i++) begin
			hw_clr[i] = ack_go && (ack_num == STD_NUMS[i*5 +: 5]);
		end
		hw_clr[4] = 1'b0;
		hw_clr[5] = 1'b0;
		hw_clr[6] = 1'b0;
		hw_clr[11] = 1'b0;
	end
	// Software clears by writing a one; SFLG: serial, timer 2, externals 2..5; TCTL: ext0/1, timers 0/1; EICTL: wdt
	assign sw_clr = {wr_eictl && wbyte[BIT_WDT], wr_sflg ? wbyte[6:0] : 7'h00,
		wr_tctl && wbyte[BIT_TF1], wr_tctl && wbyte[BIT_IE1],
		wr_tctl && wbyte[BIT_TF0], wr_tctl && wbyte[BIT_IE0]};
	assign flag_clr = hw_clr | sw_clr;
	always_comb begin
		// Set wins over a clear in the same cycle
		nxt_flag = flag_set | (flag_ff & ~flag_clr);
		if (!it_ff[0]) nxt_flag[0] = pin_low[0];
		if (!it_ff[1]) nxt_flag[2] = pin_low[1];
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			flag_ff <= '0;
		end else begin
			flag_ff <= nxt_flag;
		end
	end
	// ----------------------------------------
	// Auxiliary group
	// ----------------------------------------
	// Bit order of aie_ff matches i_aux_evt bit for bit
	wire [7:0] aux_masked = i_aux_evt & aie_ff;
	logic ai_ff;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			ai_ff <= 1'b0;
		end else begin
			ai_ff <= |aux_masked;
		end
	end
	wire aux_req = ai_ff && eai_ff;
	// ----------------------------------------
	// Priority resolution
	// ----------------------------------------
	assign std_en = {eien_ff, ien_ff[6:0]} & {NSTD{ien_ff[BIT_EA]}};
	assign std_pri = {eipri_ff, ipri_ff[6:0]};
	wire [NSTD-1:0] std_req = flag_ff & std_en;
	aasic_sel_t sel_hi;
	aasic_sel_t sel_lo;
	assign sel_hi = pick(std_req & std_pri);
	assign sel_lo = pick(std_req & ~std_pri);
	// Auxiliary always beats both standard levels
	always_comb begin
		taken = sel_lo;
		if (sel_hi.valid) taken = sel_hi;
		if (aux_req) taken = '{valid: 1'b1, num: NUM_AUX};
	end
	// Request drops for one cycle after each ack so flags can settle
	// Address tracks the winner even while idle (03h then); only o_vec_req qualifies it
	logic [7:0] vec_ff;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			req_ff <= 1'b0;
			num_ff <= '0;
			vec_ff <= '0;
		end else if (ack_go) begin
			req_ff <= 1'b0;
		end else begin
			req_ff <= taken.valid;
			num_ff <= taken.num;
			vec_ff <= vec_of(taken.num);
		end
	end
	// ----------------------------------------
	// Event status and interrupt line
	// ----------------------------------------
	logic [NEVT-1:0] istat_ff;
	logic ai_d_ff;
	logic irq_ff;
	wire [NEVT-1:0] ev_set = {ai_ff && !ai_d_ff, ack_go};
	wire [NEVT-1:0] ev_clr = wr_istat ? wbyte[NEVT-1:0] : '0;
	wire [NEVT-1:0] nxt_istat = ev_set | (istat_ff & ~ev_clr);
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			istat_ff <= '0;
			ai_d_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			istat_ff <= nxt_istat;
			ai_d_ff <= ai_ff;
			irq_ff <= |(nxt_istat & imask_ff);
		end
	end
	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	wire read_select = apol_ff[BIT_READ_SELECT];
	wire [7:0] aie_rd = read_select ? aie_ff : i_aux_evt;
	wire [7:0] apol_rd = read_select ? i_aux_evt : aie_ff;
	wire [7:0] eictl_rd = {2'b00, eai_ff, ai_ff, flag_ff[11], 3'b000};
	wire [7:0] tctl_rd = {flag_ff[3], 1'b0, flag_ff[1], 1'b0, flag_ff[2], it_ff[1],
		flag_ff[0], it_ff[0]};
	always_comb begin
		nxt_rdata = '0;
		case (bus.address)
			OFS_AIE: nxt_rdata[7:0] = aie_rd;
			OFS_APOL: nxt_rdata[7:0] = apol_rd;
			OFS_EICTL: nxt_rdata[7:0] = eictl_rd;
			OFS_IEN: nxt_rdata[7:0] = ien_ff;
			OFS_IPRI: nxt_rdata[7:0] = ipri_ff;
			OFS_EIEN: nxt_rdata[4:0] = eien_ff;
			OFS_EIPRI: nxt_rdata[4:0] = eipri_ff;
			OFS_TCTL: nxt_rdata[7:0] = tctl_rd;
			OFS_SFLG: nxt_rdata[6:0] = flag_ff[10:4];
			OFS_ISTAT: nxt_rdata[NEVT-1:0] = istat_ff;
			OFS_IMASK: nxt_rdata[NEVT-1:0] = imask_ff;
			OFS_VSTAT: nxt_rdata[8:0] = {req_ff, vec_ff};
			default: nxt_rdata = '0;
		endcase
	end
	assign o_avs_readdata = rdata_ff;
	assign o_avs_waitrequest = wait_ff;
	assign o_vec_req = req_ff;
	assign o_vec_addr = vec_ff;
	assign o_irq = irq_ff;
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_ack_t0;
		ack_go && num_ff == STD_NUMS[9:5] && !flag_set[1];
	endsequence
	a_aux_sets_pending: assert property (@(posedge i_core_clk) disable iff (i_rst)
		|aux_masked |=> ai_ff) else $error("aux pending not set");
	a_aux_group_mask: assert property (@(posedge i_core_clk) disable iff (i_rst)
		req_ff && num_ff == NUM_AUX |-> $past(eai_ff)) else $error("aux vector while masked");
	a_aux_bit_map: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_aux_evt[0] && aie_ff[0]) |=> ai_ff) else $error("aux bit0 not mapped");
	a_aux_high_map: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_aux_evt[7] && aie_ff[7]) |=> ai_ff) else $error("aux bit7 not mapped");
	a_read_select_one: assert property (@(posedge i_core_clk) disable iff (i_rst)
		rd_cap && read_select && bus.address == OFS_APOL |=> o_avs_readdata[7:0] == $past(i_aux_evt))
		else $error("raw events not read");
	a_read_select_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
		rd_cap && !read_select && bus.address == OFS_APOL |=> o_avs_readdata[7:0] == $past(aie_ff))
		else $error("enable contents not read");
	a_edge_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
		ack_go && num_ff == STD_NUMS[39:35] && !flag_set[7] |=> !flag_ff[7])
		else $error("edge flag not cleared");
	a_level_track: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!it_ff[0] |=> flag_ff[0] == $past(pin_low[0])) else $error("level flag latched");
	a_timer_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
		s_ack_t0 |=> !flag_ff[1]) else $error("timer flag not cleared");
	a_global_gate: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!ien_ff[BIT_EA] && !aux_req |=> !req_ff) else $error("vector without global enable");
	// Aux must win over any standard source of either level
	sequence s_aux_win;
		aux_req && !ack_go;
	endsequence
	a_aux_beats_std: assert property (@(posedge i_core_clk) disable iff (i_rst)
		s_aux_win |=> req_ff && num_ff == NUM_AUX) else $error("aux lost arbitration");
	a_high_beats_low: assert property (@(posedge i_core_clk) disable iff (i_rst)
		sel_hi.valid && !aux_req && !ack_go |=> num_ff == $past(sel_hi.num))
		else $error("high group lost arbitration");
	a_level_track_one: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!it_ff[1] |=> flag_ff[2] == $past(pin_low[1])) else $error("level flag 1 latched");
	a_ack_drops_req: assert property (@(posedge i_core_clk) disable iff (i_rst)
		ack_go |=> !o_vec_req) else $error("request held after ack");
	// Interrupt line is the registered OR of unmasked status bits
	a_irq_follows: assert property (@(posedge i_core_clk) disable iff (i_rst)
		1'b1 |=> o_irq == |(istat_ff & $past(imask_ff))) else $error("irq line wrong");
	a_wait_take: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(bus.read || bus.write) && wait_ff |=> !o_avs_waitrequest)
		else $error("access not answered");
	a_wait_release: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!wait_ff |=> o_avs_waitrequest) else $error("waitrequest low too long");
endmodule : aasic_ctrl
`default_nettype wire

// ---- verification/aasic_core_model.sv ----
// Purpose: Core side model that takes interrupt vectors
// Assumes: A request may drop before the core acknowledges it
// Notes: The bench sets the ack delay, so the core answers promptly or slowly
`default_nettype none
module aasic_core_model (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_vec_req,
	input wire logic [7:0] i_vec_addr,
	input wire logic [2:0] i_delay,
	output logic o_vec_ack,
	output logic [7:0] o_last,
	output int o_count
);
	logic [2:0] wait_ff;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_vec_ack <= 1'b0;
			o_last <= 8'h00;
			o_count <= 0;
			wait_ff <= 3'h0;
		end else if (o_vec_ack) begin
			// One cycle ack; a request already withdrawn is not counted
			o_vec_ack <= 1'b0;
			wait_ff <= 3'h0;
			if (i_vec_req) begin
				o_last <= i_vec_addr;
				o_count <= o_count + 1;
			end
		end else if (i_vec_req) begin
			if (wait_ff >= i_delay) o_vec_ack <= 1'b1;
			else wait_ff <= wait_ff + 3'h1;
		end
	end
endmodule : aasic_core_model
`default_nettype wire

// ---- verification/tb.sv ----
// Purpose: Self-checking bench of the interrupt controller
// Assumes: Registers reached over Avalon-MM; core model takes vectors
// Notes: Random values from a fixed seed, corner cases written by hand
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import aasic_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [5:0] addr = 6'h00;
	logic [31:0] wdata = 32'h0;
	logic [7:0] aux = 8'h00;
	logic [5:0] ext_n = 6'h3f;
	logic [5:0] pul = 6'h00;
	logic [2:0] dly = 3'h0;
	logic [31:0] rdata;
	logic wreq, ack, req, irq;
	logic [7:0] vaddr, last;
	int cnt, n_mismatch = 0, tests_run = 0, cyc = 0;
	int en_o[8] = '{OFS_IEN, OFS_EIEN, OFS_IEN, OFS_IEN, OFS_IEN, OFS_IEN, OFS_IEN, OFS_EIEN};
	int en_b[8] = '{0, 0, 1, 3, 4, 5, 6, 4};
	int fl_o[8] = '{OFS_TCTL, OFS_SFLG, OFS_TCTL, OFS_TCTL, OFS_SFLG, OFS_SFLG, OFS_SFLG, OFS_EICTL};
	int fl_b[8] = '{BIT_IE0, 3, BIT_TF0, BIT_TF1, 0, 1, 2, BIT_WDT};
	int num[8] = '{0, 8, 1, 3, 4, 5, 7, 12};
	aasic_ctrl aasic_ctrl_i (.i_core_clk(clk), .i_rst(rst), .i_avs_address(addr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wreq), .i_aux_evt(aux), .i_ext_n(ext_n), .i_tmr_ovf(pul[1:0]),
		.i_ser0_evt(pul[2]), .i_tmr2_evt(pul[3]), .i_ser1_evt(pul[4]), .i_wdt_evt(pul[5]),
		.i_vec_ack(ack), .o_vec_req(req), .o_vec_addr(vaddr), .o_irq(irq));
	aasic_core_model aasic_core_model_i (.i_core_clk(clk), .i_rst(rst), .i_vec_req(req),
		.i_vec_addr(vaddr), .i_delay(dly), .o_vec_ack(ack), .o_last(last), .o_count(cnt));
	always #12.5 clk = ~clk;
	// Hang guard: the whole sequence needs well under this many cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			complete_run();
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic logic [7:0] vec_of(input int n);
		return 8'(n * 8 + 3);
	endfunction : vec_of
	task automatic complete_run();
		$display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (e !== g) begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			n_mismatch++;
		end
	endtask : chk
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= {24'h000000, d};
		do @(posedge clk); while (wreq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic wrr(input logic [5:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wrr
	task automatic rdc(input string n, input logic [5:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(n, e, q);
	endtask : rdc
	task automatic rdb(input string n, input logic [5:0] a, input int b, input logic e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(n, {31'h0, e}, {31'h0, q[b]});
	endtask : rdb
	task automatic vec(input logic want, input logic [7:0] a);
		int c0;
		c0 = cnt;
		for (int i = 0; i < 40 && cnt == c0; i++) @(posedge clk);
		if (want) chk("vector address", {24'h0, a}, {24'h0, last});
		chk("vector taken", {31'h0, want}, {31'h0, cnt != c0});
	endtask : vec
	task automatic fire(input int k);
		@(posedge clk);
		if (k < 2) ext_n[k * 2] <= 1'b0;
		else pul[k - 2] <= 1'b1;
		@(posedge clk);
		pul <= 6'h00;
		repeat (4) @(posedge clk);
		ext_n <= 6'h3f;
		repeat (5) @(posedge clk);
	endtask : fire
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		int k;
		logic [7:0] ev, e;
		logic s, aux_group_enable;
		void'($urandom(32'h8a5f));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wrr(6'h30, 8'hff);
		// Vector status shows the idle winner's address 03h once reset is over
		for (int a = 0; a <= 48; a += 4) begin
			rdc("reset value", 6'(a), (6'(a) == OFS_VSTAT) ? {29'h0, VEC_LOW} : 32'h0);
		end
		for (int i = 0; i < 16; i++) begin
			k = i % 8;
			ev = 8'($urandom);
			ev[k] = i[3];
			aux_group_enable = 1'($urandom);
			dly <= 3'($urandom);
			wrr(OFS_AIE, 8'h01 << k);
			wrr(OFS_EICTL, {2'b00, aux_group_enable, 5'h00});
			@(posedge clk);
			aux <= ev;
			vec(ev[k] & aux_group_enable, 8'h33);
			rdb("aux pending", OFS_EICTL, BIT_AI, ev[k]);
			aux <= 8'h00;
			repeat (6) @(posedge clk);
		end
		wrr(OFS_EICTL, 8'h00);
		for (int i = 0; i < 6; i++) begin
			ev = 8'($urandom);
			e = 8'($urandom);
			s = i[0];
			aux <= ev;
			wrr(OFS_AIE, e);
			wrr(OFS_APOL, {7'h00, s});
			rdc("polarity read", OFS_APOL, {24'h0, s ? ev : e});
			rdc("enable read", OFS_AIE, {24'h0, s ? e : ev});
		end
		aux <= 8'h00;
		wrr(OFS_APOL, 8'h00);
		wrr(OFS_AIE, 8'h00);
		wrr(OFS_TCTL, 8'h01);
		for (int j = 0; j < 8; j++) begin
			wrr(6'(en_o[j]), 8'h01 << en_b[j]);
			fire(j);
			vec(1'b0, 8'h00);
			rdb("flag set", 6'(fl_o[j]), fl_b[j], 1'b1);
			wrr(OFS_IEN, (en_o[j] == OFS_IEN ? 8'h01 << en_b[j] : 8'h00) | 8'h80);
			vec(1'b1, vec_of(num[j]));
			rdb("flag after vector", 6'(fl_o[j]), fl_b[j], j >= 4);
			wrr(OFS_IEN, 8'h00);
			wrr(OFS_EIEN, 8'h00);
			wrr(6'(fl_o[j]), 8'h01 << fl_b[j]);
			rdb("flag cleared", 6'(fl_o[j]), fl_b[j], 1'b0);
		end
		// High group beats natural order: timer 2 high, serial 0 low
		wrr(OFS_IPRI, 8'h20);
		fire(4);
		fire(5);
		wrr(OFS_IEN, 8'hb0);
		vec(1'b1, vec_of(5));
		wrr(OFS_IEN, 8'h00);
		wrr(OFS_IPRI, 8'h00);
		wrr(OFS_SFLG, 8'h03);
		rdc("flags cleared", OFS_SFLG, 32'h0);
		// Level mode: flag must drop with the pin, no latching
		ext_n[0] <= 1'b0;
		repeat (5) @(posedge clk);
		rdb("level flag", OFS_TCTL, BIT_IE0, 1'b1);
		ext_n[0] <= 1'b1;
		repeat (5) @(posedge clk);
		rdb("level flag", OFS_TCTL, BIT_IE0, 1'b0);
		chk("irq masked", 32'h0, {31'h0, irq});
		wrr(OFS_IMASK, 8'h01);
		repeat (2) @(posedge clk);
		chk("irq raised", 32'h1, {31'h0, irq});
		wrr(OFS_ISTAT, 8'h03);
		repeat (2) @(posedge clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		complete_run();
	end
endmodule : tb
`default_nettype wire
